/* File: ctl_pkg.sv */
`default_nettype none
package ctl_pkg;

	// ******************************************************************
	// Geometry
	// ******************************************************************
	localparam int NUM_PAGES = 4;
	localparam int PAGE_W    = 2;
	localparam int SLOT_W    = 4;
	localparam int DATA_W    = 16;
	localparam int NUM_SLOTS = 12;
	localparam int FLAG_W    = 7;
	localparam int CORR_W    = 20;

	// ******************************************************************
	// Command codes
	// ******************************************************************
	localparam logic [7:0] CMD_OC_FAULT   = 8'h46;
	localparam logic [7:0] CMD_OC_WARN    = 8'h4a;
	localparam logic [7:0] CMD_RC_FAULT   = 8'h4b;
	localparam logic [7:0] CMD_GAIN_TC    = 8'hf6;
	localparam logic [7:0] CMD_OT_FAULT   = 8'h4f;
	localparam logic [7:0] CMD_OT_WARN    = 8'h51;
	localparam logic [7:0] CMD_UT_WARN    = 8'h52;
	localparam logic [7:0] CMD_UT_FAULT   = 8'h53;
	localparam logic [7:0] CMD_SELF_HEAT  = 8'hb8;
	localparam logic [7:0] CMD_TAU_INV    = 8'hb9;
	localparam logic [7:0] CMD_THETA      = 8'hba;
	localparam logic [7:0] CMD_DIODE_GAIN = 8'hf8;
	localparam logic [7:0] CMD_DIODE_OFS  = 8'hf9;
	localparam logic [7:0] CMD_SUP_STATUS = 8'hd0;

	// ******************************************************************
	// Storage slots inside one page
	// ******************************************************************
	localparam logic [3:0] SL_OC_FAULT   = 4'h0;
	localparam logic [3:0] SL_OC_WARN    = 4'h1;
	localparam logic [3:0] SL_RC_FAULT   = 4'h2;
	localparam logic [3:0] SL_GAIN_TC    = 4'h3;
	localparam logic [3:0] SL_OT_FAULT   = 4'h4;
	localparam logic [3:0] SL_OT_WARN    = 4'h5;
	localparam logic [3:0] SL_UT_WARN    = 4'h6;
	localparam logic [3:0] SL_UT_FAULT   = 4'h7;
	localparam logic [3:0] SL_TAU_INV    = 4'h8;
	localparam logic [3:0] SL_THETA      = 4'h9;
	localparam logic [3:0] SL_DIODE_GAIN = 4'ha;
	localparam logic [3:0] SL_DIODE_OFS  = 4'hb;

	// ******************************************************************
	// Reset values
	// ******************************************************************
	localparam logic [15:0] RST_OC_FAULT   = 16'hd280;
	localparam logic [15:0] RST_OC_WARN    = 16'hca80;
	localparam logic [15:0] RST_RC_FAULT   = 16'hb400;
	localparam logic [15:0] RST_GAIN_TC    = 16'h0000;
	localparam logic [15:0] RST_OT_FAULT   = 16'hea08;
	localparam logic [15:0] RST_OT_WARN    = 16'he3c0;
	localparam logic [15:0] RST_UT_WARN    = 16'h8000;
	localparam logic [15:0] RST_UT_FAULT   = 16'hcd80;
	localparam logic [15:0] RST_TAU_INV    = 16'h8000;
	localparam logic [15:0] RST_THETA      = 16'h8000;
	localparam logic [15:0] RST_DIODE_GAIN = 16'h4000;
	localparam logic [15:0] RST_DIODE_OFS  = 16'h8000;

	// ******************************************************************
	// Fixed-point arithmetic
	// ******************************************************************
	localparam int FRAC_T     = 4;
	localparam int FRAC_TAU   = 12;
	localparam int FRAC_GAIN  = 14;
	localparam int FRAC_CORR  = 16;
	localparam int PPM_SHIFT  = 20;
	localparam longint PPM_MUL     = 64'sd4295;
	localparam logic signed [31:0] KELVIN_OFS_Q4 = 32'sd4370;
	localparam logic signed [31:0] ROOM_Q4       = 32'sd400;
	localparam logic signed [31:0] HEAT_MAX_Q4   = 32'sd800;
	localparam logic signed [31:0] TAU_ONE_Q12   = 32'sd4096;
	localparam logic signed [31:0] RC_MAX_Q4     = -32'sd1;
	localparam longint CORR_ONE = 64'sd65536;
	localparam longint CORR_MIN = 64'sd16384;
	localparam longint CORR_MAX = 64'sd262144;
	localparam logic [4:0] HEAT_EXP = 5'h1c;

	// ******************************************************************
	// Status flag positions
	// ******************************************************************
	localparam int FL_OC_FAULT = 0;
	localparam int FL_OC_WARN  = 1;
	localparam int FL_RC_FAULT = 2;
	localparam int FL_OT_FAULT = 3;
	localparam int FL_OT_WARN  = 4;
	localparam int FL_UT_WARN  = 5;
	localparam int FL_UT_FAULT = 6;

	function automatic logic [15:0] slot_reset(input logic [3:0] slot);
		case (slot)
			SL_OC_FAULT:   slot_reset = RST_OC_FAULT;
			SL_OC_WARN:    slot_reset = RST_OC_WARN;
			SL_RC_FAULT:   slot_reset = RST_RC_FAULT;
			SL_GAIN_TC:    slot_reset = RST_GAIN_TC;
			SL_OT_FAULT:   slot_reset = RST_OT_FAULT;
			SL_OT_WARN:    slot_reset = RST_OT_WARN;
			SL_UT_WARN:    slot_reset = RST_UT_WARN;
			SL_UT_FAULT:   slot_reset = RST_UT_FAULT;
			SL_TAU_INV:    slot_reset = RST_TAU_INV;
			SL_THETA:      slot_reset = RST_THETA;
			SL_DIODE_GAIN: slot_reset = RST_DIODE_GAIN;
			SL_DIODE_OFS:  slot_reset = RST_DIODE_OFS;
			default:       slot_reset = 16'h0000;
		endcase
	endfunction : slot_reset

	// Short float word (5-bit exponent, 11-bit mantissa) to fixed point.
	function automatic logic signed [31:0] l11_fix(input logic [15:0] v,
		input int fb);
		logic signed [31:0] m;
		int                 sh;
		m  = 32'(signed'(v[10:0]));
		sh = int'(signed'(v[15:11])) + fb;
		if (sh >= 0) begin
			l11_fix = m <<< sh;
		end else begin
			l11_fix = m >>> (-sh);
		end
	endfunction : l11_fix

endpackage : ctl_pkg
`default_nettype wire

/* File: ctl_page_mem.sv */
`default_nettype none
module ctl_page_mem
	import ctl_pkg::*;
#(
	parameter int ADDR_W = PAGE_W + SLOT_W,
	parameter int WIDTH  = DATA_W
) (
	// Clock and reset
	input  wire logic              sys_clk_in,
	input  wire logic              rstn_in,
	// Write port
	input  wire logic              wr_en_in,
	input  wire logic [ADDR_W-1:0] wr_addr_in,
	input  wire logic [WIDTH-1:0]  wr_data_in,
	// Read port A
	input  wire logic [ADDR_W-1:0] rda_addr_in,
	output var  logic [WIDTH-1:0]  rda_data_out,
	// Read port B
	input  wire logic [ADDR_W-1:0] rdb_addr_in,
	output var  logic [WIDTH-1:0]  rdb_data_out
);

	localparam int DEPTH = 1 << ADDR_W;

	logic [WIDTH-1:0] mem [DEPTH];

	// Reset restores every slot of every page to its default.
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= WIDTH'(slot_reset(4'(i)));
			end
		end else if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		rda_data_out <= mem[rda_addr_in];
		rdb_data_out <= mem[rdb_addr_in];
	end

endmodule : ctl_page_mem
`default_nettype wire

/* File: ctl_supervisor.sv */
`default_nettype none
module ctl_supervisor
	import ctl_pkg::*;
#(
	parameter int PAGES = NUM_PAGES
) (
	// Clock and reset
	input  wire logic                    sys_clk_in,
	input  wire logic                    rstn_in,
	// Command port
	input  wire logic [PAGE_W-1:0]       cmd_page_in,
	input  wire logic [7:0]              cmd_code_in,
	input  wire logic                    cmd_wr_in,
	input  wire logic                    cmd_rd_in,
	input  wire logic [DATA_W-1:0]       cmd_wdata_in,
	output logic      [DATA_W-1:0]       cmd_rdata_out,
	output logic                         cmd_ack_out,
	output logic                         cmd_err_out,
	// Measurements
	input  wire logic                    meas_valid_in,
	input  wire logic [PAGE_W-1:0]       meas_page_in,
	input  wire logic [15:0]             ext_kelvin_in,
	input  wire logic                    diode_ok_in,
	input  wire logic signed [15:0]      die_temp_in,
	input  wire logic signed [15:0]      iout_in,
	input  wire logic [15:0]             dissip_in,
	// Results
	output logic                         result_valid_out,
	output logic      [PAGE_W-1:0]       result_page_out,
	output logic signed [15:0]           temperature_out,
	output logic      [CORR_W-1:0]       gain_corr_out,
	output logic      [PAGES*FLAG_W-1:0] alarm_out,
	output logic                         busy_out
);

	// ******************************************************************
	// Command decode
	// ******************************************************************
	typedef enum logic [1:0] {
		SRC_MEM    = 2'h0,
		SRC_HEAT   = 2'h1,
		SRC_STATUS = 2'h2,
		SRC_NONE   = 2'h3
	} ctl_src_t;

	logic [4:0] dec;
	logic       dec_valid;
	logic       is_heat;
	logic       is_status;
	logic       cmd_known;
	logic       mem_we;

	function automatic logic [4:0] cmd_slot(input logic [7:0] code);
		case (code)
			CMD_OC_FAULT:   cmd_slot = {1'b1, SL_OC_FAULT};
			CMD_OC_WARN:    cmd_slot = {1'b1, SL_OC_WARN};
			CMD_RC_FAULT:   cmd_slot = {1'b1, SL_RC_FAULT};
			CMD_GAIN_TC:    cmd_slot = {1'b1, SL_GAIN_TC};
			CMD_OT_FAULT:   cmd_slot = {1'b1, SL_OT_FAULT};
			CMD_OT_WARN:    cmd_slot = {1'b1, SL_OT_WARN};
			CMD_UT_WARN:    cmd_slot = {1'b1, SL_UT_WARN};
			CMD_UT_FAULT:   cmd_slot = {1'b1, SL_UT_FAULT};
			CMD_TAU_INV:    cmd_slot = {1'b1, SL_TAU_INV};
			CMD_THETA:      cmd_slot = {1'b1, SL_THETA};
			CMD_DIODE_GAIN: cmd_slot = {1'b1, SL_DIODE_GAIN};
			CMD_DIODE_OFS:  cmd_slot = {1'b1, SL_DIODE_OFS};
			default:        cmd_slot = 5'h00;
		endcase
	endfunction : cmd_slot

	assign dec       = cmd_slot(cmd_code_in);
	assign dec_valid = dec[SLOT_W];
	assign is_heat   = (cmd_code_in == CMD_SELF_HEAT);
	assign is_status = (cmd_code_in == CMD_SUP_STATUS);
	assign cmd_known = dec_valid | is_heat | is_status;
	// Words are stored exactly as written; clamping happens on use.
	assign mem_we    = cmd_wr_in & dec_valid;

	// ******************************************************************
	// Engine state
	// ******************************************************************
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_LOAD = 6'b000010,
		S_TEMP = 6'b000100,
		S_HEAT = 6'b001000,
		S_CORR = 6'b010000,
		S_CMP  = 6'b100000
	} ctl_state_t;

	ctl_state_t                state;
	ctl_state_t                next_state;
	logic [SLOT_W:0]           ld_cnt;
	logic [DATA_W-1:0]         ld [NUM_SLOTS];
	logic [DATA_W-1:0]         rdb_data;
	logic [DATA_W-1:0]         rda_data;
	logic [PAGE_W-1:0]         m_page;
	logic [15:0]               m_kel;
	logic                      m_ok;
	logic signed [15:0]        m_die;
	logic signed [15:0]        m_iout;
	logic [15:0]               m_pwr;
	logic signed [31:0]        temp_q4;
	logic signed [15:0]        heat [PAGES];
	logic [FLAG_W-1:0]         sticky [PAGES];
	logic [FLAG_W-1:0]         live_flags;
	logic [FLAG_W-1:0]         clr_mask;
	ctl_src_t                  rd_src;
	logic                      rd_pend;
	logic                      wr_pend;
	logic                      err_pend;
	logic [PAGE_W-1:0]         rd_page;

	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (meas_valid_in) begin
					next_state = S_LOAD;
				end
			end
			S_LOAD: begin
				if (ld_cnt == (SLOT_W+1)'(NUM_SLOTS)) begin
					next_state = S_TEMP;
				end
			end
			S_TEMP:  next_state = S_HEAT;
			S_HEAT:  next_state = S_CORR;
			S_CORR:  next_state = S_CMP;
			S_CMP:   next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	ctl_page_mem u_mem (
		.sys_clk_in   (sys_clk_in),
		.rstn_in      (rstn_in),
		.wr_en_in     (mem_we),
		.wr_addr_in   ({cmd_page_in, dec[SLOT_W-1:0]}),
		.wr_data_in   (cmd_wdata_in),
		.rda_addr_in  ({cmd_page_in, dec[SLOT_W-1:0]}),
		.rda_data_out (rda_data),
		.rdb_addr_in  ({m_page, ld_cnt[SLOT_W-1:0]}),
		.rdb_data_out (rdb_data)
	);

	// ******************************************************************
	// Arithmetic
	// ******************************************************************
	logic signed [31:0] ofs_q4;
	logic signed [63:0] kel_prod;
	logic signed [31:0] ext_q4;
	logic signed [31:0] theta_q4;
	logic signed [31:0] tau_q12;
	logic signed [31:0] target_q4;
	logic signed [31:0] cur_heat;
	logic signed [31:0] step_heat;
	logic signed [31:0] heat_raw;
	logic signed [15:0] heat_clamped;
	logic signed [31:0] dt_q4;
	logic signed [63:0] corr_raw;
	logic signed [63:0] corr_clamped;
	logic signed [31:0] oc_thr;
	logic signed [31:0] rc_thr;
	logic signed [31:0] iout_q4;

	assign ofs_q4   = l11_fix(ld[SL_DIODE_OFS], FRAC_T);
	assign kel_prod = 64'(m_kel) * 64'(ld[SL_DIODE_GAIN]);
	assign ext_q4   = 32'(kel_prod >>> FRAC_GAIN) - KELVIN_OFS_Q4
		+ ofs_q4;
	assign theta_q4 = l11_fix(ld[SL_THETA], FRAC_T);
	assign tau_q12  = l11_fix(ld[SL_TAU_INV], FRAC_TAU);
	assign target_q4 = 32'((64'(theta_q4) * 64'(m_pwr)) >>> FRAC_T);
	assign cur_heat  = 32'(heat[m_page]);
	assign step_heat = 32'((64'(target_q4 - cur_heat) * 64'(tau_q12))
		>>> FRAC_TAU);

	// A non-positive time constant or resistance zeroes the estimate,
	// and an inverse time constant of one or more jumps straight to the target.
	always_comb begin
		if ((tau_q12 <= 0) || (theta_q4 <= 0)) begin
			heat_raw = '0;
		end else if (tau_q12 >= TAU_ONE_Q12) begin
			heat_raw = target_q4;
		end else begin
			heat_raw = cur_heat + step_heat;
		end
		if (heat_raw < 0) begin
			heat_clamped = '0;
		end else if (heat_raw > HEAT_MAX_Q4) begin
			heat_clamped = 16'(HEAT_MAX_Q4);
		end else begin
			heat_clamped = 16'(heat_raw);
		end
	end

	// The ppm scaling is a fixed multiply-and-shift approximation of 1e-6;
	// it trades a tiny gain error for avoiding a divider.
	assign dt_q4    = temp_q4 + cur_heat - ROOM_Q4;
	assign corr_raw = CORR_ONE + (((64'(signed'(ld[SL_GAIN_TC]))
		* 64'(dt_q4)) * PPM_MUL) >>> PPM_SHIFT);
	assign corr_clamped = (corr_raw < CORR_MIN) ? CORR_MIN :
		(corr_raw > CORR_MAX) ? CORR_MAX : corr_raw;

	assign oc_thr = (l11_fix(ld[SL_OC_FAULT], FRAC_T) < 0) ? '0 :
		l11_fix(ld[SL_OC_FAULT], FRAC_T);
	assign rc_thr = (l11_fix(ld[SL_RC_FAULT], FRAC_T) > RC_MAX_Q4) ?
		RC_MAX_Q4 : l11_fix(ld[SL_RC_FAULT], FRAC_T);
	assign iout_q4 = 32'(m_iout);

	always_comb begin
		live_flags = '0;
		live_flags[FL_OC_FAULT] = iout_q4 > oc_thr;
		live_flags[FL_OC_WARN]  = iout_q4 > l11_fix(ld[SL_OC_WARN], FRAC_T);
		live_flags[FL_RC_FAULT] = iout_q4 < rc_thr;
		live_flags[FL_OT_FAULT] = temp_q4 >
			l11_fix(ld[SL_OT_FAULT], FRAC_T);
		live_flags[FL_OT_WARN]  = temp_q4 >
			l11_fix(ld[SL_OT_WARN], FRAC_T);
		live_flags[FL_UT_WARN]  = temp_q4 <
			l11_fix(ld[SL_UT_WARN], FRAC_T);
		live_flags[FL_UT_FAULT] = temp_q4 <
			l11_fix(ld[SL_UT_FAULT], FRAC_T);
	end

	assign clr_mask = (cmd_wr_in && is_status) ?
		cmd_wdata_in[FLAG_W-1:0] : '0;

	// ******************************************************************
	// Engine sequencing
	// ******************************************************************
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			ld_cnt <= '0;
			m_page <= '0;
			m_kel  <= '0;
			m_ok   <= 1'b0;
			m_die  <= '0;
			m_iout <= '0;
			m_pwr  <= '0;
		end else if (state == S_IDLE) begin
			ld_cnt <= '0;
			if (meas_valid_in) begin
				m_page <= meas_page_in;
				m_kel  <= ext_kelvin_in;
				m_ok   <= diode_ok_in;
				m_die  <= die_temp_in;
				m_iout <= iout_in;
				m_pwr  <= dissip_in;
			end
		end else if (state == S_LOAD) begin
			ld_cnt <= ld_cnt + 1'b1;
		end
	end

	// Slot k is addressed at count k and arrives one count later.
	always_ff @(posedge sys_clk_in) begin
		if (state == S_LOAD && ld_cnt != '0) begin
			ld[ld_cnt[SLOT_W-1:0] - 1'b1] <= rdb_data;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			temp_q4 <= '0;
		end else if (state == S_TEMP) begin
			temp_q4 <= m_ok ? ext_q4 : 32'(m_die);
		end
	end

	generate
		for (genvar p = 0; p < PAGES; p++) begin : g_page
			always_ff @(posedge sys_clk_in) begin
				if (!rstn_in) begin
					heat[p]   <= '0;
					sticky[p] <= '0;
					alarm_out[p*FLAG_W +: FLAG_W] <= '0;
				end else begin
					if (state == S_HEAT && m_page == PAGE_W'(p)) begin
						heat[p] <= heat_clamped;
					end
					// A flag raised in the clearing cycle survives.
					if (state == S_CMP && m_page == PAGE_W'(p)) begin
						sticky[p] <= (sticky[p] & ~((cmd_page_in ==
							PAGE_W'(p)) ? clr_mask : '0)) | live_flags;
						alarm_out[p*FLAG_W +: FLAG_W] <= live_flags;
					end else if (cmd_page_in == PAGE_W'(p)) begin
						sticky[p] <= sticky[p] & ~clr_mask;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			result_valid_out <= 1'b0;
			result_page_out  <= '0;
			temperature_out  <= '0;
			gain_corr_out    <= CORR_W'(CORR_ONE);
			busy_out         <= 1'b0;
		end else begin
			result_valid_out <= (state == S_CMP);
			busy_out         <= (next_state != S_IDLE);
			if (state == S_CORR) begin
				result_page_out <= m_page;
				temperature_out <= 16'(temp_q4);
				gain_corr_out   <= CORR_W'(corr_clamped);
			end
		end
	end

	// ******************************************************************
	// Command answer, two cycles after the strobe
	// ******************************************************************
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			rd_pend  <= 1'b0;
			wr_pend  <= 1'b0;
			err_pend <= 1'b0;
			rd_src   <= SRC_NONE;
			rd_page  <= '0;
		end else begin
			rd_pend  <= cmd_rd_in;
			wr_pend  <= cmd_wr_in & ~cmd_rd_in;
			err_pend <= cmd_rd_in ? ~cmd_known :
				(cmd_wr_in & ~(dec_valid | is_status));
			rd_page  <= cmd_page_in;
			rd_src   <= dec_valid ? SRC_MEM : is_heat ? SRC_HEAT :
				is_status ? SRC_STATUS : SRC_NONE;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			cmd_rdata_out <= '0;
			cmd_ack_out   <= 1'b0;
			cmd_err_out   <= 1'b0;
		end else begin
			cmd_ack_out <= rd_pend | wr_pend;
			cmd_err_out <= (rd_pend | wr_pend) & err_pend;
			cmd_rdata_out <= '0;
			if (rd_pend) begin
				case (rd_src)
					SRC_MEM:    cmd_rdata_out <= rda_data;
					SRC_HEAT:   cmd_rdata_out <= {HEAT_EXP,
						heat[rd_page][10:0]};
					SRC_STATUS: cmd_rdata_out <= DATA_W'(sticky[rd_page]);
					default:    cmd_rdata_out <= '0;
				endcase
			end
		end
	end

endmodule : ctl_supervisor
`default_nettype wire

/* File: ctl_properties.sv */
`default_nettype none
module ctl_properties
	import ctl_pkg::*;
#(
	parameter int PAGES = NUM_PAGES
) (
	// Clock and reset
	input wire logic              sys_clk_in,
	input wire logic              rstn_in,
	// Command port
	input wire logic [7:0]        cmd_code_in,
	input wire logic              cmd_wr_in,
	input wire logic              cmd_rd_in,
	input wire logic [DATA_W-1:0] cmd_rdata_out,
	input wire logic              cmd_ack_out,
	input wire logic              cmd_err_out,
	// Measurement port
	input wire logic              meas_valid_in,
	input wire logic              result_valid_out,
	input wire logic [CORR_W-1:0] gain_corr_out,
	input wire logic              busy_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	sequence s_strobe;
		cmd_rd_in || cmd_wr_in;
	endsequence
	sequence s_take;
		meas_valid_in && !busy_out;
	endsequence

	a_ack_latency: assert property (s_strobe |-> ##2 cmd_ack_out)
		else $error("ack not two edges after strobe");
	a_ack_cause: assert property (cmd_ack_out |->
		$past(cmd_rd_in || cmd_wr_in, 2))
		else $error("ack without strobe");
	a_err_with_ack: assert property (cmd_err_out |-> cmd_ack_out)
		else $error("err without ack");
	a_rdata_idle: assert property (!cmd_ack_out |-> cmd_rdata_out == '0)
		else $error("read word outside ack");
	a_ro_refused: assert property (cmd_wr_in && !cmd_rd_in &&
		cmd_code_in == CMD_SELF_HEAT |-> ##2 cmd_err_out)
		else $error("write to read-only word accepted");
	a_result_latency: assert property (s_take |->
		##18 result_valid_out)
		else $error("result late");
	a_busy_hold: assert property (s_take |=> busy_out[*8])
		else $error("busy dropped early");
	a_result_pulse: assert property (result_valid_out |=>
		!result_valid_out)
		else $error("result pulse too long");
	a_corr_range: assert property (result_valid_out |->
		gain_corr_out >= 20'h04000 && gain_corr_out <= 20'h40000)
		else $error("correction out of range");
	a_corr_hold: assert property (!$stable(gain_corr_out) |=>
		result_valid_out)
		else $error("correction moved between results");
endmodule : ctl_properties

bind ctl_supervisor ctl_properties #(.PAGES(PAGES)) u_props (
	.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
	.cmd_code_in(cmd_code_in), .cmd_wr_in(cmd_wr_in),
	.cmd_rd_in(cmd_rd_in), .cmd_rdata_out(cmd_rdata_out),
	.cmd_ack_out(cmd_ack_out), .cmd_err_out(cmd_err_out),
	.meas_valid_in(meas_valid_in), .result_valid_out(result_valid_out),
	.gain_corr_out(gain_corr_out), .busy_out(busy_out));
`default_nettype wire

/* File: ctl_sensor_model.sv */
`default_nettype none
module ctl_sensor_model
	import ctl_pkg::*;
(
	// Request from the bench
	input  wire logic              go_in,
	input  wire logic [PAGE_W-1:0] page_in,
	input  wire logic [15:0]       kelvin_in,
	input  wire logic              ok_in,
	input  wire logic [15:0]       die_in,
	input  wire logic [15:0]       iout_in,
	input  wire logic [15:0]       dissip_in,
	// Measurement set toward the block
	output logic                   meas_valid_out,
	output logic [PAGE_W-1:0]      meas_page_out,
	output logic [15:0]            ext_kelvin_out,
	output logic                   diode_ok_out,
	output logic [15:0]            die_temp_out,
	output logic [15:0]            iout_out,
	output logic [15:0]            dissip_out
);
	// Outside a set the lines show the inverse, so sampling at a wrong
	// edge gives garbage rather than a stale value that happens to match.
	assign meas_valid_out = go_in;
	assign meas_page_out  = go_in ? page_in : ~page_in;
	assign ext_kelvin_out = go_in ? kelvin_in : ~kelvin_in;
	assign diode_ok_out   = go_in ? ok_in : ~ok_in;
	assign die_temp_out   = go_in ? die_in : ~die_in;
	assign iout_out       = go_in ? iout_in : ~iout_in;
	assign dissip_out     = go_in ? dissip_in : ~dissip_in;
endmodule : ctl_sensor_model
`default_nettype wire

/* File: current_temp_limit_calibration_bench.sv */
`default_nettype none
module current_temp_limit_calibration_bench
	import ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in = 0, rstn_in = 0, cmd_wr_in = 0, cmd_rd_in = 0;
	logic go = 0, ok = 0, cmd_ack_out, cmd_err_out, result_valid_out;
	logic busy_out, meas_valid, diode_ok;
	logic [1:0] cmd_page_in = 0, mpg = 0, meas_page, result_page_out;
	logic [7:0] cmd_code_in = 0;
	logic [15:0] cmd_wdata_in = 0, kel = 0, die = 0, cur = 0, dis = 0;
	logic [15:0] cmd_rdata_out, ext_kelvin, die_temp, iout, dissip;
	logic [15:0] temperature_out;
	logic [CORR_W-1:0] gain_corr_out;
	logic [NUM_PAGES*FLAG_W-1:0] alarm_out;
	int error_cnt = 0, cmp_count = 0, i;
	logic [7:0] codes [10] = '{CMD_OT_FAULT, CMD_OT_WARN, CMD_UT_WARN,
		CMD_UT_FAULT, CMD_TAU_INV, CMD_THETA, CMD_DIODE_GAIN,
		CMD_DIODE_OFS, CMD_GAIN_TC, CMD_OC_FAULT};
	logic [15:0] dflt [10] = '{16'hea08, 16'he3c0, 16'h8000, 16'hcd80,
		16'h8000, 16'h8000, 16'h4000, 16'h8000, 16'h0000, 16'hd280};

	always #10 sys_clk_in = ~sys_clk_in;

	ctl_sensor_model model_u (.go_in(go), .page_in(mpg), .kelvin_in(kel),
		.ok_in(ok), .die_in(die), .iout_in(cur), .dissip_in(dis),
		.meas_valid_out(meas_valid), .meas_page_out(meas_page),
		.ext_kelvin_out(ext_kelvin), .diode_ok_out(diode_ok),
		.die_temp_out(die_temp), .iout_out(iout), .dissip_out(dissip));

	ctl_supervisor dut_u (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.cmd_page_in(cmd_page_in), .cmd_code_in(cmd_code_in),
		.cmd_wr_in(cmd_wr_in), .cmd_rd_in(cmd_rd_in),
		.cmd_wdata_in(cmd_wdata_in), .cmd_rdata_out(cmd_rdata_out),
		.cmd_ack_out(cmd_ack_out), .cmd_err_out(cmd_err_out),
		.meas_valid_in(meas_valid), .meas_page_in(meas_page),
		.ext_kelvin_in(ext_kelvin), .diode_ok_in(diode_ok),
		.die_temp_in(die_temp), .iout_in(iout), .dissip_in(dissip),
		.result_valid_out(result_valid_out),
		.result_page_out(result_page_out),
		.temperature_out(temperature_out), .gain_corr_out(gain_corr_out),
		.alarm_out(alarm_out), .busy_out(busy_out));

	// ****************************************************************
	// Compare, closing and access tasks
	// ****************************************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task end_of_test;
		$display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test

	task automatic wait_for(ref logic sig);
		int n;
		for (n = 0; n < 30; n++) begin
			@(posedge sys_clk_in);
			#1;
			if (sig === 1'b1) break;
		end
		if (n == 30) begin
			error_cnt++;
			$display("Error %0t: no answer", $time);
			end_of_test;
		end
	endtask : wait_for

	task cmd(input logic [1:0] pg, input logic [7:0] cd, input logic wr,
		input logic [15:0] d, input logic [15:0] exp, input logic er);
		@(posedge sys_clk_in);
		cmd_page_in  <= pg;
		cmd_code_in  <= cd;
		cmd_wr_in    <= wr;
		cmd_rd_in    <= !wr;
		cmd_wdata_in <= d;
		@(posedge sys_clk_in);
		cmd_wr_in <= 1'b0;
		cmd_rd_in <= 1'b0;
		wait_for(cmd_ack_out);
		chk(cmd_err_out, er);
		chk(cmd_rdata_out, wr ? 16'h0000 : exp);
	endtask : cmd

	// Measurement set with the reported temperature, correction and flags.
	task meas(input logic [1:0] pg, input logic [15:0] k, input logic o,
		input logic [15:0] dt, input logic [15:0] c, input logic [15:0] ds,
		input logic [15:0] et, input logic [19:0] eg, input logic [6:0] fl);
		@(posedge sys_clk_in);
		go  <= 1'b1;
		mpg <= pg;
		kel <= k;
		ok  <= o;
		die <= dt;
		cur <= c;
		dis <= ds;
		@(posedge sys_clk_in);
		go <= 1'b0;
		wait_for(result_valid_out);
		chk(result_page_out, pg);
		chk(temperature_out, et);
		chk(gain_corr_out, eg);
		chk(alarm_out[pg*FLAG_W+:FLAG_W], fl);
	endtask : meas

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (3) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		for (i = 0; i < 10; i++) begin
			cmd(i[1:0], codes[i], 0, 0, dflt[i], 0);
		end
		$display("defaults done");
		cmd(1, CMD_OC_FAULT, 1, 16'hfc00, 0, 0);
		cmd(1, CMD_OC_FAULT, 0, 0, 16'hfc00, 0);
		cmd(1, CMD_RC_FAULT, 1, 16'h0002, 0, 0);
		cmd(1, CMD_RC_FAULT, 0, 0, 16'h0002, 0);
		cmd(2, CMD_GAIN_TC, 1, 16'h0f3c, 0, 0);
		cmd(2, CMD_GAIN_TC, 0, 0, 16'h0f3c, 0);
		cmd(1, CMD_GAIN_TC, 0, 0, 16'h0000, 0);
		cmd(0, CMD_SELF_HEAT, 1, 16'h1234, 0, 1);
		cmd(0, 8'h00, 0, 0, 0, 1);
		$display("registers done");
		meas(1, 16'd4800, 1, 0, 16'd16, 0, 16'd430, 20'h10000, 7'h01);
		meas(1, 16'd4800, 1, 0, 16'hfff0, 0, 16'd430, 20'h10000, 7'h04);
		cmd(1, CMD_SUP_STATUS, 0, 0, 16'h0005, 0);
		cmd(1, CMD_SUP_STATUS, 1, 16'h007f, 0, 0);
		cmd(1, CMD_SUP_STATUS, 0, 0, 16'h0000, 0);
		cmd(3, CMD_DIODE_GAIN, 1, 16'h2000, 0, 0);
		cmd(3, CMD_DIODE_OFS, 1, 16'h0001, 0, 0);
		meas(3, 16'd4800, 1, 0, 0, 0, 16'hf85e, 20'h10000, 7'h60);
		meas(3, 16'd4800, 0, 16'd480, 0, 0, 16'd480, 20'h10000, 7'h00);
		$display("temperature done");
		cmd(0, CMD_GAIN_TC, 1, 16'h7fff, 0, 0);
		meas(0, 16'd9200, 1, 0, 0, 0, 16'd4830, 20'h40000, 7'h18);
		cmd(0, CMD_GAIN_TC, 1, 16'h8000, 0, 0);
		meas(0, 16'd9200, 1, 0, 0, 0, 16'd4830, 20'h04000, 7'h18);
		$display("correction done");
		cmd(0, CMD_GAIN_TC, 1, 16'h0000, 0, 0);
		cmd(0, CMD_TAU_INV, 1, 16'h0001, 0, 0);
		cmd(0, CMD_THETA, 1, 16'h0064, 0, 0);
		meas(0, 16'd4800, 1, 0, 0, 16'd16, 16'd430, 20'h10000, 7'h00);
		cmd(0, CMD_SELF_HEAT, 0, 0, 16'he320, 0);
		cmd(1, CMD_SELF_HEAT, 0, 0, 16'he000, 0);
		$display("self-heating done");
		end_of_test;
	end
endmodule : current_temp_limit_calibration_bench
`default_nettype wire
